/* File: rtl/dctx_pkg.sv */
// Package for the buffered D-channel transmitter: offsets, fields, states.
// Assumes an 8-bit microport with a 7-bit control-page address.
package dctx_pkg;
  // Control page offsets
  localparam logic [6:0] ADDR_FIFO_WRITE = 7'h44;
  localparam logic [6:0] ADDR_CONTROL = 7'h45;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Control register field positions
  localparam int BIT_IRQ_SELECT = 7;
  localparam int BIT_IRQ_LEVEL = 6;
  localparam int BIT_RATE_HI = 5;
  localparam int BIT_RATE_LO = 4;
  localparam int BIT_MSG_MODE = 3;
  localparam int BIT_PARITY = 2;
  localparam int BIT_FRAMING = 1;
  localparam int BIT_GO = 0;
  // Rate codes
  localparam logic [1:0] RATE_1 = 2'h0;
  localparam logic [1:0] RATE_2 = 2'h1;
  localparam logic [1:0] RATE_8 = 2'h2;
  // FIFO sizing and level threshold
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam logic [5:0] LEVEL_THREE_QUARTER = 6'h08;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  // Serialiser states, Gray coded along the usual path
  typedef enum logic [2:0] {
    DCTX_IDLE = 3'h0,
    DCTX_START = 3'h1,
    DCTX_DATA = 3'h3,
    DCTX_PARITY = 3'h2,
    DCTX_STOP = 3'h6
  } dctx_state_t;
  // Microport access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dctx_bus_t;
  // One bit time of the selected channel
  typedef struct packed {
    logic valid;
    logic [2:0] index;
  } dctx_slot_t;
endpackage

/* File: rtl/dctx_mem.sv */
// Small byte memory holding the transmit FIFO contents.
// Read data is registered: valid one clock after the address is presented.
module dctx_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic i_core_clk,
  input wire logic i_wr,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [DEPTH];

  // Write port
  always_ff @(posedge i_core_clk) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read port
  always_ff @(posedge i_core_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule

/* File: rtl/dctx_top.sv */
// Buffered D-channel transmitter: 32-byte FIFO and channel serialiser.
// Assumes slot pulses mark each of the 8 bit times of the selected
// channel, at least three clocks apart; all inputs synchronous.
//
// Notes on behaviour
// R01: Software loads bytes at address 44h.
// R02: FIFO holds 32 bytes at most.
// R03: Message length equals bytes written.
// R04: Level interrupt when select bit is 0.
// R05: End interrupt when select bit is 1.
// R06: Level is empty, or 8 bytes left.
// R07: Rate field picks 1, 2 or 8 bits.
// R08: Mode bit picks message or FIFO-level.
// R09: Parity bit added when enabled, framed only.
// R10: FIFO-level mode framing follows framing bit.
// R11: Message mode always adds start and stop.
// R12: Go bit set starts the transmission.
// R13: Go bit written 0 empties FIFO.
// R14: Bit order comes from receive control.
// R15: Order 0 sends bit 0 first.
// R16: Idle channel bits are driven high.
module dctx_top (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire dctx_pkg::dctx_bus_t i_bus,
  input wire dctx_pkg::dctx_slot_t i_slot,
  input wire logic i_tx_irq_enable,
  input wire logic i_tx_bit_order,
  output logic [7:0] o_rdata,
  output logic o_tx_bit,
  output logic o_tx_strobe,
  output logic o_irq
);
  logic [7:0] control;
  logic [4:0] wptr;
  logic [4:0] rptr;
  logic [5:0] count;
  logic [5:0] fill;
  logic [7:0] mem_rdata;
  logic [7:0] hold;
  logic hold_valid;
  logic pop_pending;
  logic [7:0] shifter;
  logic [2:0] bit_count;
  logic parity_acc;
  logic done_flag;
  dctx_pkg::dctx_state_t state;
  logic fifo_wr;
  logic pop;
  logic clear;
  logic msg_mode;
  logic framed;
  logic parity_on;
  logic slot_active;
  logic take_byte;
  logic out_bit;
  logic send_bit;
  logic finish;
  logic next_hold_used;
  dctx_pkg::dctx_state_t next_state;

  // Bit time is used when its index is below the chosen rate
  function automatic logic slot_used(input logic [1:0] rate,
                                     input logic [2:0] index);
    case (rate)
      dctx_pkg::RATE_2: slot_used = (index < 3'h2);
      dctx_pkg::RATE_8: slot_used = 1'b1;
      default: slot_used = (index == 3'h0);
    endcase
  endfunction

  // Bytes held: FIFO words plus the prefetched byte awaiting the serialiser
  assign fill = count + {5'h00, hold_valid || pop_pending}; // R02 R06

  // Decode and mode terms
  assign fifo_wr = i_bus.wr && (i_bus.addr == dctx_pkg::ADDR_FIFO_WRITE) &&
                   (fill < 6'(dctx_pkg::FIFO_DEPTH)); // R01 R02
  assign clear = i_bus.wr && (i_bus.addr == dctx_pkg::ADDR_CONTROL) &&
                 !i_bus.wdata[dctx_pkg::BIT_GO]; // R13
  assign msg_mode = control[dctx_pkg::BIT_MSG_MODE]; // R08
  assign framed = msg_mode || control[dctx_pkg::BIT_FRAMING]; // R10 R11
  assign parity_on = framed && control[dctx_pkg::BIT_PARITY]; // R09
  assign slot_active = i_slot.valid &&
    slot_used(control[dctx_pkg::BIT_RATE_HI:dctx_pkg::BIT_RATE_LO],
              i_slot.index); // R07
  assign pop = !hold_valid && !pop_pending && (count != 6'h00) && !clear;
  // Next data bit by the selected order
  assign out_bit = i_tx_bit_order ? shifter[7] : shifter[0]; // R14 R15

  // Control register, software write
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      control <= dctx_pkg::CONTROL_RESET;
    end else if (i_bus.wr && i_bus.addr == dctx_pkg::ADDR_CONTROL) begin
      control <= i_bus.wdata;
    end
  end

  // Read-back of the control register; FIFO port reads as zero
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd) begin
      o_rdata <= (i_bus.addr == dctx_pkg::ADDR_CONTROL) ? control : 8'h00;
    end
  end

  // FIFO pointers and fill count
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || clear) begin
      wptr <= 5'h00; // R13
      rptr <= 5'h00;
      count <= 6'h00;
    end else begin
      if (fifo_wr) begin
        wptr <= wptr + 5'h01;
      end
      if (pop) begin
        rptr <= rptr + 5'h01;
      end
      count <= count + 6'(fifo_wr) - 6'(pop);
    end
  end

  dctx_mem #(
    .DEPTH(dctx_pkg::FIFO_DEPTH),
    .AW(dctx_pkg::FIFO_AW)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_wr(fifo_wr),
    .i_waddr(wptr),
    .i_wdata(i_bus.wdata),
    .i_raddr(rptr),
    .o_rdata(mem_rdata)
  );

  // Serialiser step: what to send and where to go on a used bit time
  always_comb begin
    next_state = state;
    send_bit = 1'b1; // R16
    take_byte = 1'b0;
    finish = 1'b0;
    case (state)
      dctx_pkg::DCTX_IDLE: begin
        if (control[dctx_pkg::BIT_GO] && hold_valid) begin // R12
          take_byte = 1'b1;
          next_state = framed ? dctx_pkg::DCTX_START : dctx_pkg::DCTX_DATA;
        end
      end
      dctx_pkg::DCTX_START: begin
        send_bit = 1'b0;
        next_state = dctx_pkg::DCTX_DATA;
      end
      dctx_pkg::DCTX_DATA: begin
        send_bit = out_bit;
        if (bit_count == dctx_pkg::LAST_DATA_BIT) begin
          if (framed && !msg_mode) begin
            next_state = parity_on ? dctx_pkg::DCTX_PARITY
                                   : dctx_pkg::DCTX_STOP;
          end else if (hold_valid) begin
            take_byte = 1'b1; // R03
          end else if (msg_mode) begin
            next_state = parity_on ? dctx_pkg::DCTX_PARITY
                                   : dctx_pkg::DCTX_STOP;
          end else begin
            finish = 1'b1;
            next_state = dctx_pkg::DCTX_IDLE;
          end
        end
      end
      dctx_pkg::DCTX_PARITY: begin
        send_bit = parity_acc ^ 1'b0;
        next_state = dctx_pkg::DCTX_STOP;
      end
      dctx_pkg::DCTX_STOP: begin
        if (!msg_mode && hold_valid) begin
          take_byte = 1'b1;
          next_state = dctx_pkg::DCTX_START;
        end else begin
          finish = 1'b1;
          next_state = dctx_pkg::DCTX_IDLE;
        end
      end
      default: begin
        next_state = dctx_pkg::DCTX_IDLE;
      end
    endcase
  end

  // Byte is consumed from idle at once, elsewhere only on a used bit time
  assign next_hold_used = take_byte &&
    (state == dctx_pkg::DCTX_IDLE || slot_active);

  // Prefetch of the next byte into the hold register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || clear) begin
      hold_valid <= 1'b0;
      pop_pending <= 1'b0;
      hold <= 8'h00;
    end else begin
      pop_pending <= pop;
      if (pop_pending) begin
        hold <= mem_rdata;
        hold_valid <= 1'b1;
      end else if (next_hold_used) begin
        hold_valid <= 1'b0;
      end
    end
  end

  // Shift register, bit counter, parity and state
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || clear) begin
      state <= dctx_pkg::DCTX_IDLE;
      shifter <= 8'h00;
      bit_count <= 3'h0;
      parity_acc <= 1'b0;
    end else if (state == dctx_pkg::DCTX_IDLE) begin
      if (next_hold_used) begin
        state <= next_state;
        shifter <= hold;
        bit_count <= 3'h0;
        parity_acc <= 1'b0;
      end
    end else if (slot_active) begin
      state <= next_state;
      if (next_hold_used) begin
        shifter <= hold;
        bit_count <= 3'h0;
      end else if (state == dctx_pkg::DCTX_DATA) begin
        shifter <= i_tx_bit_order ? {shifter[6:0], 1'b0}
                                  : {1'b0, shifter[7:1]};
        bit_count <= bit_count + 3'h1;
      end
      // Even parity over the message, or over each byte in byte mode
      if (state == dctx_pkg::DCTX_DATA) begin
        parity_acc <= parity_acc ^ out_bit; // R09
      end else if (state == dctx_pkg::DCTX_STOP) begin
        parity_acc <= 1'b0;
      end
    end
  end

  // Channel output: idle ones outside a message or unused bit times
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_tx_bit <= 1'b1;
      o_tx_strobe <= 1'b0;
    end else begin
      o_tx_strobe <= i_slot.valid;
      if (i_slot.valid) begin
        o_tx_bit <= slot_active ? send_bit : 1'b1; // R16
      end
    end
  end

  // End-of-transmission flag; a new byte or a clear starts afresh
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      done_flag <= 1'b0;
    end else if (slot_active && finish) begin
      done_flag <= 1'b1; // R05
    end else if (clear || fifo_wr) begin
      done_flag <= 1'b0;
    end
  end

  // Interrupt: level of the FIFO or end of transmission
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else if (!i_tx_irq_enable) begin
      o_irq <= 1'b0;
    end else if (control[dctx_pkg::BIT_IRQ_SELECT]) begin
      o_irq <= done_flag; // R05
    end else if (control[dctx_pkg::BIT_IRQ_LEVEL]) begin
      o_irq <= (fill <= dctx_pkg::LEVEL_THREE_QUARTER); // R04 R06
    end else begin
      o_irq <= (fill == 6'h00); // R04 R06
    end
  end
endmodule

/* File: tb/dctx_checker.sv */
// Port checker for the D-channel transmitter.
// Assumes slot pulses at least three clocks apart.
module dctx_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire dctx_pkg::dctx_bus_t i_bus,
  input wire dctx_pkg::dctx_slot_t i_slot,
  input wire logic i_tx_irq_enable,
  input wire logic i_tx_bit_order,
  input wire logic [7:0] o_rdata,
  input wire logic o_tx_bit,
  input wire logic o_tx_strobe,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl;
  logic empty;
  logic [3:0] used;
  logic wr_c;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Shadow control register and used bit times per frame
  assign wr_c = i_bus.wr && i_bus.addr == dctx_pkg::ADDR_CONTROL;
  assign used = ctl[5:4] == dctx_pkg::RATE_2 ? 4'h2 :
                ctl[5:4] == dctx_pkg::RATE_8 ? 4'h8 : 4'h1;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n)
      ctl <= 8'h00;
    else if (wr_c)
      ctl <= i_bus.wdata;
  end
  // Set when the FIFO is known empty: reset or a stop write
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || (wr_c && !i_bus.wdata[0]))
      empty <= 1'b1;
    else if (i_bus.wr && i_bus.addr == dctx_pkg::ADDR_FIFO_WRITE)
      empty <= 1'b0;
  end
  chk_strobe_pulse: assert property (
    i_slot.valid |=> o_tx_strobe ##1 !o_tx_strobe) else $error("no strobe");
  chk_bit_stands: assert property (
    !i_slot.valid |=> $stable(o_tx_bit) && !o_tx_strobe)
    else $error("bit moved");
  chk_unused_idle: assert property (
    i_slot.valid && {1'b0, i_slot.index} >= used |=> o_tx_bit)
    else $error("unused bit low");
  chk_idle_high: assert property (
    i_slot.valid && !ctl[0] && !$past(ctl[0]) |=> o_tx_bit)
    else $error("idle bit low");
  chk_read_ctl: assert property (
    i_bus.rd && !i_bus.wr && i_bus.addr == dctx_pkg::ADDR_CONTROL
    |=> o_rdata == ctl) else $error("bad control read");
  chk_read_other: assert property (
    i_bus.rd && i_bus.addr > dctx_pkg::ADDR_CONTROL |=> o_rdata == 8'h00)
    else $error("bad unmapped read");
  chk_irq_off: assert property (
    !i_tx_irq_enable |=> !o_irq) else $error("irq while disabled");
  chk_irq_empty: assert property (
    (i_tx_irq_enable && !ctl[7] && empty) [*3] |-> o_irq)
    else $error("no empty irq");
endmodule
bind dctx_top dctx_checker dctx_checker_inst (.i_core_clk, .i_rst_n,
  .i_bus, .i_slot, .i_tx_irq_enable, .i_tx_bit_order, .o_rdata,
  .o_tx_bit, .o_tx_strobe, .o_irq);

/* File: tb/dctx_peer.sv */
// Far-side model: slot timing source and channel bit receiver.
// Assumes the transmitter answers one clock after each slot pulse.
module dctx_peer (
  input wire logic i_core_clk,
  input wire logic [3:0] i_gap,
  input wire logic [3:0] i_used,
  input wire logic i_tx_bit,
  input wire logic i_tx_strobe,
  output dctx_pkg::dctx_slot_t o_slot
);
  timeunit 1ns;
  timeprecision 1ns;
  logic q[$];
  int cnt = 0;
  // Slot pulses i_gap+1 clocks apart, index walking 0..7
  initial begin
    o_slot = '0;
    forever begin
      @(posedge i_core_clk);
      #1;
      if (cnt >= i_gap) begin
        o_slot = '{1'b1, o_slot.index + 3'h1};
        cnt = 0;
      end else begin
        o_slot.valid = 1'b0;
        cnt++;
      end
    end
  end
  // Keep used channel bits from the first low bit onward
  always @(posedge i_core_clk)
    if (i_tx_strobe && {1'b0, o_slot.index} < i_used)
      if (q.size() > 0 || !i_tx_bit)
        q.push_back(i_tx_bit);
endmodule

/* File: tb/tb.sv */
// Testbench for the D-channel transmitter: registers, framing, interrupts.
// Assumes the far-side model of dctx_peer.sv.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 0;
  logic i_rst_n = 0;
  logic i_tx_irq_enable = 0;
  logic i_tx_bit_order = 0;
  dctx_pkg::dctx_bus_t i_bus = '0;
  dctx_pkg::dctx_slot_t i_slot;
  logic [7:0] o_rdata;
  logic o_tx_bit, o_tx_strobe, o_irq;
  logic [3:0] gap = 4'h2;
  logic [3:0] used = 4'h1;
  int seed = 32'h2dd342a1;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] cfg [9] = '{8'h01, 8'h13, 8'h27, 8'h09, 8'h9d, 8'ha9,
                          8'h6b, 8'h31, 8'ha9};
  dctx_top dctx_top_inst (.i_core_clk, .i_rst_n, .i_bus, .i_slot,
    .i_tx_irq_enable, .i_tx_bit_order, .o_rdata, .o_tx_bit,
    .o_tx_strobe, .o_irq);
  dctx_peer dctx_peer_inst (.i_core_clk, .i_gap(gap), .i_used(used),
    .i_tx_bit(o_tx_bit), .i_tx_strobe(o_tx_strobe), .o_slot(i_slot));
  initial forever #5 i_core_clk = ~i_core_clk;
  // Comparison and register access helpers
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [6:0] a, input logic [7:0] v);
    i_bus = '{w, !w, a, v};
    @(posedge i_core_clk);
    #1 i_bus = '0;
    @(posedge i_core_clk);
    #1;
  endtask
  // One message: load bytes, start, compare channel bits with the model
  task automatic run(input int t, input int n);
    logic [7:0] c, b;
    logic e[$];
    logic p, g;
    int k, j;
    c = cfg[t];
    p = 0;
    used = c[5:4] == 2'h1 ? 4'h2 : c[5:4] == 2'h2 ? 4'h8 : 4'h1;
    gap = 4'h2 + 4'($random(seed) & 3);
    i_tx_irq_enable = 1'($random(seed));
    i_tx_bit_order = 1'($random(seed));
    bus(1, dctx_pkg::ADDR_CONTROL, c & 8'hfe);
    if (c[3]) e.push_back(0);
    for (k = 0; k < n; k++) begin
      b = 8'($random(seed));
      if (k == 0 && !c[3] && !c[1]) b[i_tx_bit_order ? 7 : 0] = 0;
      bus(1, dctx_pkg::ADDR_FIFO_WRITE, b);
      if (k >= 32) continue;
      if (!c[3] && c[1]) e.push_back(0);
      for (j = 0; j < 8; j++) e.push_back(b[i_tx_bit_order ? 7 - j : j]);
      p ^= ^b;
      if (!c[3] && c[1] && c[2]) e.push_back(^b);
      if (!c[3] && c[1]) e.push_back(1);
    end
    if (c[3] && c[2]) e.push_back(p);
    if (c[3]) e.push_back(1);
    dctx_peer_inst.q.delete();
    bus(1, dctx_pkg::ADDR_CONTROL, c);
    bus(0, dctx_pkg::ADDR_CONTROL, 8'h00);
    cmp(o_rdata, c);
    for (k = 0; k < 15000 && dctx_peer_inst.q.size() < e.size() + 9; k++)
      @(posedge i_core_clk);
    #1;
    for (k = 0; k < e.size() + 9; k++) begin
      g = dctx_peer_inst.q[k];
      b = {7'h0, k < e.size() ? e[k] : 1'b1};
      cmp({7'h0, g}, b);
    end
    cmp({7'h0, o_irq}, {7'h0, i_tx_irq_enable});
    $display("test %0d done", t);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge i_core_clk);
    #1 i_rst_n = 1;
    cmp({5'h0, o_irq, o_tx_strobe, o_tx_bit}, 8'h01);
    bus(0, dctx_pkg::ADDR_CONTROL, 8'h00);
    cmp(o_rdata, 8'h00);
    for (int t = 0; t < 8; t++) run(t, 1 + ($random(seed) & 3));
    run(8, 33);
    i_tx_irq_enable = 1;
    bus(1, dctx_pkg::ADDR_CONTROL, 8'h40);
    repeat (8) bus(1, dctx_pkg::ADDR_FIFO_WRITE, 8'h5a);
    cmp({7'h0, o_irq}, 8'h01);
    bus(1, dctx_pkg::ADDR_FIFO_WRITE, 8'ha5);
    cmp({7'h0, o_irq}, 8'h00);
    bus(0, 7'h46, 8'h00);
    cmp(o_rdata, 8'h00);
    bus(1, dctx_pkg::ADDR_CONTROL, 8'h00);
    cmp({7'h0, o_irq}, 8'h01);
    bus(0, dctx_pkg::ADDR_CONTROL, 8'h00);
    cmp(o_rdata, 8'h00);
    cmp({7'h0, o_irq}, 8'h01);
    $display("test irq done");
    end_of_test;
  end
  // Watchdog
  initial begin
    #900000;
    fail_count++;
    end_of_test;
  end
endmodule
